// ==== logic/ebpio_defines.vh ====
// Register indices, field layout, reset values and drive codes for the 8-bit port
`ifndef EBPIO_DEFINES_VH
`define EBPIO_DEFINES_VH

// Register indices; the byte address on the bus is four times the index
`define EBPIO_IDX_PIN_LEVEL 16'hF238
`define EBPIO_IDX_PIN_DIRECTION 16'hF239
`define EBPIO_IDX_DRIVE_CTRL_LOW 16'hF23A
`define EBPIO_IDX_DRIVE_CTRL_HIGH 16'hF23B
`define EBPIO_IDX_FUNC_SEL_LOW 16'hF23C
`define EBPIO_IDX_FUNC_SEL_HIGH 16'hF23D

// Bus geometry
`define EBPIO_ADR_W 18
`define EBPIO_IDX_LSB 2
`define EBPIO_IDX_MSB 17

// Reset values
`define EBPIO_RST_PIN_LEVEL 8'h00
`define EBPIO_RST_PIN_DIRECTION 8'h00
`define EBPIO_RST_DRIVE_CTRL 8'h00
`define EBPIO_RST_FUNC_SEL 8'h00

// Direction bit encoding
`define EBPIO_DIR_OUTPUT 1'h0
`define EBPIO_DIR_INPUT 1'h1

// Drive code {ctrl_high bit, ctrl_low bit}
`define EBPIO_CODE_HIZ 2'h0
`define EBPIO_CODE_PCH_OD 2'h1
`define EBPIO_CODE_NCH_OD 2'h2
`define EBPIO_CODE_CMOS 2'h3

`endif

// ==== logic/ebpio_sync.v ====
// Two-flop synchroniser for the sensed pin levels
`timescale 1ns/1ps

module ebpio_sync #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Asynchronous levels in, synchronised levels out
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;

  // First stage feeds only the second stage
  always @(posedge clk_i) begin
    if (rst_i) begin
      stage1_reg <= {WIDTH{1'b0}};
      stage2_reg <= {WIDTH{1'b0}};
    end else begin
      stage1_reg <= async_i;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_o = stage2_reg;

endmodule // ebpio_sync

// ==== logic/ebpio_pin_cell.v ====
// One pin's pad driver: direction plus drive code into output, enable and pulls
`timescale 1ns/1ps
`include "ebpio_defines.vh"

module ebpio_pin_cell (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Configuration of this pin
  input wire level_i,
  input wire dir_i,
  input wire ctrl_low_i,
  input wire ctrl_high_i,
  // Pad controls
  output reg pad_out_o,
  output reg pad_oe_o,
  output reg pull_up_o,
  output reg pull_down_o
);

  reg out_next;
  reg oe_next;
  reg pu_next;
  reg pd_next;
  wire [1:0] code;

  assign code = {ctrl_high_i, ctrl_low_i};

  // Decode mode and code; open drain drives only one level, else floats
  always @* begin
    out_next = 1'b0;
    oe_next = 1'b0;
    pu_next = 1'b0;
    pd_next = 1'b0;
    if (dir_i == `EBPIO_DIR_OUTPUT) begin
      case (code)
        `EBPIO_CODE_PCH_OD: begin
          out_next = 1'b1;
          oe_next = level_i;
        end
        `EBPIO_CODE_NCH_OD: begin
          out_next = 1'b0;
          oe_next = ~level_i;
        end
        `EBPIO_CODE_CMOS: begin
          out_next = level_i;
          oe_next = 1'b1;
        end
        default: begin
          out_next = 1'b0;
          oe_next = 1'b0;
        end
      endcase
    end else begin
      // Input mode: pad released, only pulls may act
      case (code)
        `EBPIO_CODE_PCH_OD: pd_next = 1'b1;
        `EBPIO_CODE_NCH_OD: pu_next = 1'b1;
        default: begin
          pu_next = 1'b0;
          pd_next = 1'b0;
        end
      endcase
    end
  end

  // Registered pad controls keep glitches off the pins
  always @(posedge clk_i) begin
    if (rst_i) begin
      pad_out_o <= 1'b0;
      pad_oe_o <= 1'b0;
      pull_up_o <= 1'b0;
      pull_down_o <= 1'b0;
    end else begin
      pad_out_o <= out_next;
      pad_oe_o <= oe_next;
      pull_up_o <= pu_next;
      pull_down_o <= pd_next;
    end
  end

endmodule // ebpio_pin_cell

// ==== logic/ebpio_port.v ====
// Top of the 8-bit port: Wishbone register file, pin sensing and pad drivers
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
`include "ebpio_defines.vh"

// What this block does
// - An 8-bit read/write pin-level register at index F238 resets to 00, bit n for pin n.
// - An 8-bit read/write direction register at index F239 resets to 00, byte access only.
// - Drive-control bytes at F23A and F23B reset to zero and form one 16-bit word at F23A.
// - Function-select bytes at F23C and F23D reset to zero and form one 16-bit word at F23C.
// - A pin in output mode is driven with its stored pin-level bit by the CMOS code, at one level only by open drain, not at all by hi-Z.
// - Reading pin-level returns the written value for pins in output mode.
// - Reading pin-level returns the sensed pad level for pins in input mode.
// - A pin-level bit of 0 means low and 1 means high, both driven and sensed.
// - Direction bit 0 selects output and 1 input, so all pins start as outputs.
// - Pin code {high,low} picks hi-Z/P-OD/N-OD/CMOS out or hi-Z/pull-down/pull-up/hi-Z in.
module ebpio_port (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone classic slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [`EBPIO_ADR_W-1:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // Port pins
  input wire [7:0] pad_in_i,
  output wire [7:0] pad_out_o,
  output wire [7:0] pad_oe_o,
  output wire [7:0] pull_up_o,
  output wire [7:0] pull_down_o,
  // Toward the peripheral function mux
  output reg [7:0] func_sel_low_o,
  output reg [7:0] func_sel_high_o
);

  // Register storage
  reg [7:0] pin_level_reg;
  reg [7:0] pin_direction_reg;
  reg [7:0] pin_drive_ctrl_low_reg;
  reg [7:0] pin_drive_ctrl_high_reg;
  reg [7:0] pin_function_sel_low_reg;
  reg [7:0] pin_function_sel_high_reg;

  // Next values
  reg [7:0] pin_level_next;
  reg [7:0] pin_direction_next;
  reg [7:0] pin_drive_ctrl_low_next;
  reg [7:0] pin_drive_ctrl_high_next;
  reg [7:0] pin_function_sel_low_next;
  reg [7:0] pin_function_sel_high_next;
  reg [31:0] dat_next;

  // Bus decode
  wire [15:0] idx;
  wire req;
  wire wr_cycle;
  wire hit_level;
  wire hit_dir;
  wire hit_ctrl_lo;
  wire hit_ctrl_hi;
  wire hit_func_lo;
  wire hit_func_hi;

  // Byte write enables for the two single registers
  wire wr_level;
  wire wr_dir;

  // Byte write enables for the word pairs, per lane
  wire wr_ctrl_lo_b0;
  wire wr_ctrl_lo_b1;
  wire wr_ctrl_hi_b0;
  wire wr_func_lo_b0;
  wire wr_func_lo_b1;
  wire wr_func_hi_b0;

  // Sensed pins and the value seen when reading pin-level
  wire [7:0] pad_sync;
  wire [7:0] pin_level_view;

  // Each register owns one 32-bit word; the byte address is four times the index
  assign idx = adr_i[`EBPIO_IDX_MSB:`EBPIO_IDX_LSB];

  // One access per request; the ack cycle itself is not a new request
  assign req = cyc_i & stb_i & ~ack_o;
  assign wr_cycle = req & we_i;

  // Index compare, one per register
  assign hit_level = (idx == `EBPIO_IDX_PIN_LEVEL);
  assign hit_dir = (idx == `EBPIO_IDX_PIN_DIRECTION);
  assign hit_ctrl_lo = (idx == `EBPIO_IDX_DRIVE_CTRL_LOW);
  assign hit_ctrl_hi = (idx == `EBPIO_IDX_DRIVE_CTRL_HIGH);
  assign hit_func_lo = (idx == `EBPIO_IDX_FUNC_SEL_LOW);
  assign hit_func_hi = (idx == `EBPIO_IDX_FUNC_SEL_HIGH);

  // Lane 0 carries every byte access; lane 1 counts only at a word index
  assign wr_level = wr_cycle & hit_level & sel_i[0];
  assign wr_dir = wr_cycle & hit_dir & sel_i[0];
  assign wr_ctrl_lo_b0 = wr_cycle & hit_ctrl_lo & sel_i[0];
  assign wr_ctrl_lo_b1 = wr_cycle & hit_ctrl_lo & sel_i[1];
  assign wr_ctrl_hi_b0 = wr_cycle & hit_ctrl_hi & sel_i[0];
  assign wr_func_lo_b0 = wr_cycle & hit_func_lo & sel_i[0];
  assign wr_func_lo_b1 = wr_cycle & hit_func_lo & sel_i[1];
  assign wr_func_hi_b0 = wr_cycle & hit_func_hi & sel_i[0];

  // Pad levels come from outside the clock domain
  // Two flops cost input pins two cycles of read latency, traded for metastability margin
  ebpio_sync #(
    .WIDTH(8)
  ) u_pad_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(pad_in_i),
    .sync_o(pad_sync)
  );

  // Output pins read back the latch, input pins the pad
  assign pin_level_view = (~pin_direction_reg & pin_level_reg)
                        | (pin_direction_reg & pad_sync);

  // Write decode; byte lanes pick which byte of a word pair is written
  always @* begin
    pin_level_next = pin_level_reg;
    pin_direction_next = pin_direction_reg;
    pin_drive_ctrl_low_next = pin_drive_ctrl_low_reg;
    pin_drive_ctrl_high_next = pin_drive_ctrl_high_reg;
    pin_function_sel_low_next = pin_function_sel_low_reg;
    pin_function_sel_high_next = pin_function_sel_high_reg;
    // Latch updates whatever the direction; it waits for output mode
    if (wr_level) begin
      pin_level_next = dat_i[7:0];
    end
    // Byte-only register: upper lanes are ignored
    if (wr_dir) begin
      pin_direction_next = dat_i[7:0];
    end
    // Word view at the lower index: lane 1 reaches the high byte
    if (wr_ctrl_lo_b0) begin
      pin_drive_ctrl_low_next = dat_i[7:0];
    end
    if (wr_ctrl_lo_b1) begin
      pin_drive_ctrl_high_next = dat_i[15:8];
    end
    if (wr_ctrl_hi_b0) begin
      pin_drive_ctrl_high_next = dat_i[7:0];
    end
    // Function-select pair follows the same lane pairing
    if (wr_func_lo_b0) begin
      pin_function_sel_low_next = dat_i[7:0];
    end
    if (wr_func_lo_b1) begin
      pin_function_sel_high_next = dat_i[15:8];
    end
    if (wr_func_hi_b0) begin
      pin_function_sel_high_next = dat_i[7:0];
    end
  end

  // Read mux; unmapped indices and unused bits read as zero
  always @* begin
    dat_next = 32'h00000000;
    case (idx)
      `EBPIO_IDX_PIN_LEVEL: begin
        dat_next = {24'h000000, pin_level_view};
      end
      `EBPIO_IDX_PIN_DIRECTION: begin
        dat_next = {24'h000000, pin_direction_reg};
      end
      `EBPIO_IDX_DRIVE_CTRL_LOW: begin
        dat_next = {16'h0000, pin_drive_ctrl_high_reg, pin_drive_ctrl_low_reg};
      end
      `EBPIO_IDX_DRIVE_CTRL_HIGH: begin
        dat_next = {24'h000000, pin_drive_ctrl_high_reg};
      end
      `EBPIO_IDX_FUNC_SEL_LOW: begin
        dat_next = {16'h0000, pin_function_sel_high_reg, pin_function_sel_low_reg};
      end
      `EBPIO_IDX_FUNC_SEL_HIGH: begin
        dat_next = {24'h000000, pin_function_sel_high_reg};
      end
      // Unmapped indices answer zero rather than an error
      default: begin
        dat_next = 32'h00000000;
      end
    endcase
  end

  // Pin-level latch; all pins come up as outputs in hi-Z drive
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_level_reg <= `EBPIO_RST_PIN_LEVEL;
    end else begin
      pin_level_reg <= pin_level_next;
    end
  end

  // Direction resets to all outputs so no pull acts before software asks
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_direction_reg <= `EBPIO_RST_PIN_DIRECTION;
    end else begin
      pin_direction_reg <= pin_direction_next;
    end
  end

  // Drive-control low byte, reached by byte or by word
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_drive_ctrl_low_reg <= `EBPIO_RST_DRIVE_CTRL;
    end else begin
      pin_drive_ctrl_low_reg <= pin_drive_ctrl_low_next;
    end
  end

  // Drive-control high byte, reached by its own index or word lane 1
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_drive_ctrl_high_reg <= `EBPIO_RST_DRIVE_CTRL;
    end else begin
      pin_drive_ctrl_high_reg <= pin_drive_ctrl_high_next;
    end
  end

  // Function-select low byte
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_function_sel_low_reg <= `EBPIO_RST_FUNC_SEL;
    end else begin
      pin_function_sel_low_reg <= pin_function_sel_low_next;
    end
  end

  // Function-select high byte
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_function_sel_high_reg <= `EBPIO_RST_FUNC_SEL;
    end else begin
      pin_function_sel_high_reg <= pin_function_sel_high_next;
    end
  end

  // Ack one cycle after the request; every index is acked so no master hangs
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  // Read data held until the next read, so a late sampler still sees it
  always @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h00000000;
    end else if (req && !we_i) begin
      dat_o <= dat_next;
    end
  end

  // Function select passed on raw; the mux decides what the codes mean
  always @(posedge clk_i) begin
    if (rst_i) begin
      func_sel_low_o <= `EBPIO_RST_FUNC_SEL;
    end else begin
      func_sel_low_o <= pin_function_sel_low_reg;
    end
  end

  // High byte keeps the same one-cycle lag as the low byte
  always @(posedge clk_i) begin
    if (rst_i) begin
      func_sel_high_o <= `EBPIO_RST_FUNC_SEL;
    end else begin
      func_sel_high_o <= pin_function_sel_high_reg;
    end
  end

  // One pad driver per pin
  genvar n;
  generate
    for (n = 0; n < 8; n = n + 1) begin : g_pin
      ebpio_pin_cell u_cell (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .level_i(pin_level_reg[n]),
        .dir_i(pin_direction_reg[n]),
        .ctrl_low_i(pin_drive_ctrl_low_reg[n]),
        .ctrl_high_i(pin_drive_ctrl_high_reg[n]),
        .pad_out_o(pad_out_o[n]),
        .pad_oe_o(pad_oe_o[n]),
        .pull_up_o(pull_up_o[n]),
        .pull_down_o(pull_down_o[n])
      );
    end
  endgenerate

endmodule // ebpio_port

// ==== sim/ebpio_assertions.sv ====
// Concurrent checks on the port block's bus and pad pins
`timescale 1ns/1ps
module ebpio_checker (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Bus
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [17:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  // Pads and mux
  input wire [7:0] pad_oe_o,
  input wire [7:0] pull_up_o,
  input wire [7:0] pull_down_o,
  input wire [7:0] func_sel_low_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A request the slave takes at this edge
  wire take = cyc_i && stb_i && !ack_o;
  wire [15:0] idx = adr_i[17:2];
  sequence func_wr;
    take && we_i && sel_i[0] && idx == 16'hF23C;
  endsequence
  sequence stray_rd;
    take && !we_i && (idx < 16'hF238 || idx > 16'hF23D);
  endsequence
  ack_once_a: assert property (take |=> ack_o ##1 !ack_o)
    else $error("ack not a one cycle answer");
  ack_cause_a: assert property (ack_o |-> $past(take))
    else $error("ack without a request");
  func_out_a: assert property (func_wr |=> ##1 func_sel_low_o == $past(dat_i[7:0], 2))
    else $error("function select not passed out");
  stray_zero_a: assert property (stray_rd |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  dat_hold_a: assert property (!(take && !we_i) |=> $stable(dat_o))
    else $error("read data moved without a read");
  pull_drv_a: assert property (((pull_up_o | pull_down_o) & pad_oe_o) == 8'h00)
    else $error("pull on a driven pin");
  pull_pair_a: assert property ((pull_up_o & pull_down_o) == 8'h00)
    else $error("both pulls on");
  rst_hiz_a: assert property ($fell(rst_i) |-> pad_oe_o == 8'h00 && pull_up_o == 8'h00)
    else $error("pins not idle after reset");
endmodule // ebpio_checker

bind ebpio_port ebpio_checker u_ebpio_checker (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .pad_oe_o(pad_oe_o), .pull_up_o(pull_up_o), .pull_down_o(pull_down_o),
  .func_sel_low_o(func_sel_low_o));

// ==== sim/ebpio_pins.sv ====
// Model of the eight external pins and what hangs on them
`timescale 1ns/1ps
module ebpio_pins (
  // Clock
  input wire clk_i,
  // Pad controls from the port
  input wire [7:0] pad_out_i,
  input wire [7:0] pad_oe_i,
  input wire [7:0] pull_up_i,
  input wire [7:0] pull_down_i,
  // Outside driver set by the bench
  input wire [7:0] ext_val_i,
  input wire [7:0] ext_en_i,
  // Resolved pin levels
  output wire [7:0] level_o
);
  reg [7:0] float_reg = 8'h00;
  // Floating pins wander, so a stale level never passes as sensed
  always @(posedge clk_i) begin
    float_reg <= ~float_reg;
  end
  // Port drive wins, then outside drive, then pulls
  assign level_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_en_i & ext_val_i)
    | (~pad_oe_i & ~ext_en_i & (pull_up_i | (~pull_down_i & float_reg)));
endmodule // ebpio_pins

// ==== sim/eight_bit_port_io_registers_tb.sv ====
// Register and pin tests for the 8-bit port
`timescale 1ns/1ps
module eight_bit_port_io_registers_tb;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg cyc_i = 1'b0;
  reg stb_i = 1'b0;
  reg we_i = 1'b0;
  reg [17:0] adr_i = 18'h0;
  reg [3:0] sel_i = 4'h0;
  reg [31:0] dat_i = 32'h0;
  reg [7:0] ext_val = 8'h00;
  reg [7:0] ext_en = 8'h00;
  reg [31:0] rd;
  reg [15:0] idx;
  wire [31:0] dat_o;
  wire ack_o;
  wire [7:0] lvl, pout, poe, pu, pd, fs_lo, fs_hi;
  integer error_cnt = 0;
  integer num_checks = 0;

  ebpio_port u_ebpio_port (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .pad_in_i(lvl), .pad_out_o(pout), .pad_oe_o(poe), .pull_up_o(pu), .pull_down_o(pd),
    .func_sel_low_o(fs_lo), .func_sel_high_o(fs_hi));
  ebpio_pins u_ebpio_pins (.clk_i(clk_i), .pad_out_i(pout), .pad_oe_i(poe), .pull_up_i(pu),
    .pull_down_i(pd), .ext_val_i(ext_val), .ext_en_i(ext_en), .level_o(lvl));

  // 250 MHz clock
  initial begin
    forever #2 clk_i = ~clk_i;
  end

  task check(input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // One classic cycle; flops read just after the edge give the sampled value
  task wb(input w, input [15:0] a, input [3:0] s, input [31:0] d);
    begin
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= {a, 2'b00};
      sel_i <= s;
      dat_i <= d;
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
    end
  endtask

  task rd_chk(input [15:0] a, input [31:0] m, input [31:0] exp);
    begin
      wb(1'b0, a, 4'hF, 32'h0);
      check(rd & m, exp);
    end
  endtask

  // Sync path needs two edges, so wait three before looking
  task pin_chk(input [7:0] oe, input [7:0] u, input [7:0] dn);
    begin
      repeat (3) @(posedge clk_i);
      check({poe, pu, pd}, {oe, u, dn});
    end
  endtask

  task end_sim;
    begin
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (idx = 16'hF238; idx < 16'hF23E; idx = idx + 16'h1) rd_chk(idx, 32'hFF, 32'h0);
    pin_chk(8'h00, 8'h00, 8'h00);
    wb(1'b1, 16'h0100, 4'hF, 32'hFFFFFFFF);
    rd_chk(16'h0100, 32'hFFFFFFFF, 32'h0);
    wb(1'b1, 16'hF239, 4'h2, 32'hFF00);
    rd_chk(16'hF239, 32'hFF, 32'h0);
    wb(1'b1, 16'hF238, 4'h1, 32'hA5);
    rd_chk(16'hF238, 32'hFF, 32'hA5);
    // CMOS, then P open drain, then N open drain
    wb(1'b1, 16'hF23A, 4'h3, 32'hFFFF);
    pin_chk(8'hFF, 8'h00, 8'h00);
    check(pout, 8'hA5);
    rd_chk(16'hF23B, 32'hFF, 32'hFF);
    wb(1'b1, 16'hF23A, 4'h3, 32'h00FF);
    pin_chk(8'hA5, 8'h00, 8'h00);
    check(pout, 8'hFF);
    wb(1'b1, 16'hF23B, 4'h1, 32'hFF);
    wb(1'b1, 16'hF23A, 4'h1, 32'h00);
    pin_chk(8'h5A, 8'h00, 8'h00);
    check(pout, 8'h00);
    rd_chk(16'hF23A, 32'hFFFF, 32'hFF00);
    // Outside pulls low on released pins; output reads keep the latch
    ext_en <= 8'hFF;
    rd_chk(16'hF238, 32'hFF, 32'hA5);
    ext_val <= 8'h3C;
    wb(1'b1, 16'hF239, 4'h1, 32'hFF);
    rd_chk(16'hF239, 32'hFF, 32'hFF);
    pin_chk(8'h00, 8'hFF, 8'h00);
    rd_chk(16'hF238, 32'hFF, 32'h3C);
    ext_en <= 8'h00;
    pin_chk(8'h00, 8'hFF, 8'h00);
    rd_chk(16'hF238, 32'hFF, 32'hFF);
    wb(1'b1, 16'hF23A, 4'h3, 32'h00FF);
    pin_chk(8'h00, 8'h00, 8'hFF);
    rd_chk(16'hF238, 32'hFF, 32'h00);
    wb(1'b1, 16'hF23A, 4'h3, 32'hFFFF);
    pin_chk(8'h00, 8'h00, 8'h00);
    // Latch written while input, mixed directions, then back to output
    wb(1'b1, 16'hF238, 4'h1, 32'h0F);
    ext_en <= 8'hFF;
    ext_val <= 8'hC3;
    wb(1'b1, 16'hF239, 4'h1, 32'hF0);
    pin_chk(8'h0F, 8'h00, 8'h00);
    rd_chk(16'hF238, 32'hFF, 32'hCF);
    wb(1'b1, 16'hF239, 4'h1, 32'h00);
    rd_chk(16'hF239, 32'hFF, 32'h00);
    pin_chk(8'hFF, 8'h00, 8'h00);
    check(pout, 8'h0F);
    // Function select word, then high byte alone
    wb(1'b1, 16'hF23C, 4'h3, 32'h1234);
    pin_chk(8'hFF, 8'h00, 8'h00);
    check({fs_hi, fs_lo}, 16'h1234);
    wb(1'b1, 16'hF23D, 4'h1, 32'h56);
    rd_chk(16'hF23C, 32'hFFFF, 32'h5634);
    check(fs_hi, 8'h56);
    end_sim;
  end

  // Watchdog far beyond the 140 or so cycles the tests take
  initial begin
    #100000;
    error_cnt = error_cnt + 1;
    end_sim;
  end
endmodule // eight_bit_port_io_registers_tb
